// ### sca_modem_map.svh
/*
  Constants of the modem and dialer signalling block: character codes,
  timing figures and counter limits.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef SCA_MODEM_MAP_SVH
`define SCA_MODEM_MAP_SVH

// ------------------------------------------------------------
// Characters
// ------------------------------------------------------------
`define CHAR_DLE       8'h10
`define CHAR_SYN       8'h16
`define CHAR_PAD       8'hff

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CORE_CLK_MHZ   100
`define HANGUP_MS      150
`define BIT_LAST       3'h7
`define BIT_FIRST      3'h0

`endif

// ### sca_modem_pkg.sv
/*
  Types shared by the modem and dialer signalling block.
  Assumes the constants header is available on the include path.
*/
package sca_modem_pkg;
  `include "sca_modem_map.svh"

  // ------------------------------------------------------------
  // Host controls and status
  // ------------------------------------------------------------
  typedef struct packed {
    logic start_write;
    logic start_read;
    logic stop_read;
    logic tx_last;
    logic const_carrier;
    logic answer_call;
    logic dial_active;
    logic hangup_req;
    logic svc_clear;
    logic online;
    logic processor_io_active;
  } host_ctrl_t;

  typedef struct packed {
    logic channel_active_flag;
    logic read_flag;
    logic service_request;
    logic busy_online_qual;
    logic dialer_fault;
  } host_status_t;

  // ------------------------------------------------------------
  // Link transmit states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SEND = 3'b010,
    TX_PAD  = 3'b100
  } tx_state_t;
endpackage

// ### sca_modem.sv
/*
  Modem and dialer signalling of a synchronous communications adapter,
  with its transmit FIFO. Core logic on core_clk; serial logic on the
  modem's dibit transmit clock, which also times receive data.
  Assumes the modem and calling unit pins are asynchronous to core_clk
  and that host controls are synchronous one-cycle pulses or levels.
*/
`include "sca_modem_map.svh"

// ------------------------------------------------------------
// Transmit FIFO
// ------------------------------------------------------------
module sca_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// Functional notes
// - A DLE is held back until the next character is ready so both go out back to back.
// - A character that arrives after a SYN filler was sent is loaded into the shifter next.
// - A transmission ends with one all-ones pad character.
// - The pad character is omitted when constant carrier is selected.
// - The busy-online qualifier is processor I/O active AND online.
// - The line control lead is active while answering a call or dialing out.
// - Hanging up releases the line control lead for about 150 ms.
// - Receive data is taken serially, positive level as zero and negative as one.
// - A read flag stands while the active operation is a read.
// - A timing chain moves the shift register into the receive buffer then clears it.
// - A ring indication sets the service request flag.
// - Request-to-send is positive during transmission and negative after it.
// - In two-wire use request-to-send turns the modem between send and receive.
// - Request-to-send rises on a rising edge of the dibit transmit clock.
// - The I/O busy flag stands while an operation is in progress.
module sca_modem
  import sca_modem_pkg::*;
#(
  parameter int FIFO_DEPTH    = 8,
  parameter int HANGUP_CYCLES = `HANGUP_MS * `CORE_CLK_MHZ * 1000
) (
  // Core clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  // Host side
  input  wire host_ctrl_t   ctrl,
  output host_status_t      status,
  input  wire logic         tx_valid,
  output logic              tx_ready,
  input  wire logic [7:0]   tx_char,
  output logic [7:0]        rx_char,
  output logic              rx_char_valid,
  input  wire logic         dial_valid,
  output logic              dial_ready,
  input  wire logic [3:0]   dial_digit,
  // Modem link
  input  wire logic         dibit_transmit_clock,
  input  wire logic         rx_line,
  output logic              tx_line,
  output logic              request_to_send_lead,
  output logic              line_control_lead,
  input  wire logic         ring_indicator,
  // Calling unit
  input  wire logic         next_digit_request,
  input  wire logic         dialer_power_present,
  output logic [3:0]        digit_lead,
  output logic              digit_present
);
  localparam int HW = $clog2(HANGUP_CYCLES + 1);

  // ------------------------------------------------------------
  // Core: pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] ring_sync, ndr_sync, pwr_sync, ack_sync, done_sync;
  logic [2:0] rxt_sync;
  logic       ack_tog, done_tog, rx_tog;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ring_sync <= '0;
      ndr_sync  <= '0;
      pwr_sync  <= '0;
      ack_sync  <= '0;
      done_sync <= '0;
      rxt_sync  <= '0;
    end else begin
      ring_sync <= {ring_sync[0], ring_indicator};
      ndr_sync  <= {ndr_sync[0], next_digit_request};
      pwr_sync  <= {pwr_sync[0], dialer_power_present};
      ack_sync  <= {ack_sync[0], ack_tog};
      done_sync <= {done_sync[0], done_tog};
      rxt_sync  <= {rxt_sync[1:0], rx_tog};
    end
  end

  // ------------------------------------------------------------
  // Core: character hand-off with DLE holding
  // ------------------------------------------------------------
  logic       fifo_valid, fifo_pop, hs_busy, dle_hold_flag, req_tog;
  logic       send_now, done_seen, end_req, write_op, hang_active;
  logic       done_tog_seen, read_flag, channel_active_flag;
  logic       service_request, busy_online_qual, dialer_fault;
  logic [7:0] fifo_data, tx_word;
  logic [HW-1:0] hang_cnt;

  sca_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_char),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  assign hs_busy   = (req_tog != ack_sync[1]);
  assign done_seen = (done_sync[1] != done_tog_seen);
  // A held DLE leaves only once a follower waits in the FIFO
  assign send_now  = write_op && fifo_valid && !hs_busy;
  assign fifo_pop  = send_now && !dle_hold_flag;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      dle_hold_flag <= 1'b0;
      req_tog       <= 1'b0;
      tx_word       <= '0;
      done_tog_seen <= 1'b0;
    end else begin
      done_tog_seen <= done_sync[1];
      if (send_now && dle_hold_flag) begin
        tx_word       <= `CHAR_DLE;
        req_tog       <= ~req_tog;
        dle_hold_flag <= 1'b0;
      end else if (send_now && fifo_data == `CHAR_DLE) begin
        dle_hold_flag <= 1'b1;
      end else if (send_now) begin
        tx_word <= fifo_data;
        req_tog <= ~req_tog;
      end
    end
  end

  // ------------------------------------------------------------
  // Core: operation flags and hangup
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      write_op <= 1'b0;
      end_req  <= 1'b0;
    end else if (ctrl.start_write) begin
      write_op <= 1'b1;
      end_req  <= 1'b0;
    end else if (done_seen) begin
      write_op <= 1'b0;
      end_req  <= 1'b0;
    end else if (ctrl.tx_last && write_op) begin
      end_req <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      read_flag <= 1'b0;
    end else if (ctrl.start_read) begin
      read_flag <= 1'b1;
    end else if (ctrl.stop_read) begin
      read_flag <= 1'b0;
    end
  end
  assign status = {channel_active_flag, read_flag, service_request,
                   busy_online_qual, dialer_fault};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hang_cnt <= '0;
    end else if (ctrl.hangup_req) begin
      hang_cnt <= HW'(HANGUP_CYCLES);
    end else if (hang_cnt != '0) begin
      hang_cnt <= hang_cnt - 1'b1;
    end
  end
  assign hang_active = (hang_cnt != '0);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      channel_active_flag <= 1'b0;
      line_control_lead   <= 1'b0;
      busy_online_qual    <= 1'b0;
      service_request     <= 1'b0;
      dialer_fault        <= 1'b0;
    end else begin
      channel_active_flag <= ctrl.start_write || ctrl.start_read ||
        ctrl.hangup_req || hang_active || read_flag ||
        (write_op && !done_seen);
      line_control_lead <= (ctrl.answer_call || ctrl.dial_active) &&
        !ctrl.hangup_req && !hang_active;
      busy_online_qual <= ctrl.processor_io_active &&
        ctrl.online;
      if (ring_sync[1]) begin
        service_request <= 1'b1;
      end else if (ctrl.svc_clear) begin
        service_request <= 1'b0;
      end
      dialer_fault <= ctrl.dial_active && !pwr_sync[1];
    end
  end

  // ------------------------------------------------------------
  // Core: dialer digits
  // ------------------------------------------------------------
  assign dial_ready = ctrl.dial_active && ndr_sync[1] && !digit_present &&
    pwr_sync[1];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      digit_lead    <= '0;
      digit_present <= 1'b0;
    end else if (dial_valid && dial_ready) begin
      digit_lead    <= dial_digit;
      digit_present <= 1'b1;
    end else if (!ndr_sync[1] || !ctrl.dial_active) begin
      digit_present <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Core: receive hand-over
  // ------------------------------------------------------------
  logic [7:0] receive_buffer;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_char       <= '0;
      rx_char_valid <= 1'b0;
    end else begin
      rx_char_valid <= (rxt_sync[2] != rxt_sync[1]);
      if (rxt_sync[2] != rxt_sync[1]) begin
        rx_char <= receive_buffer;
      end
    end
  end

  // ------------------------------------------------------------
  // Link: synchronisers
  // ------------------------------------------------------------
  logic [1:0] lrst_sync, req_sync, end_sync, cc_sync, rd_sync, rxd_sync;
  logic       link_rst;
  always_ff @(posedge dibit_transmit_clock) begin
    lrst_sync <= {lrst_sync[0], rst};
    req_sync  <= {req_sync[0], req_tog};
    end_sync  <= {end_sync[0], end_req && !fifo_valid && !dle_hold_flag};
    cc_sync   <= {cc_sync[0], ctrl.const_carrier};
    rd_sync   <= {rd_sync[0], status.read_flag};
    rxd_sync  <= {rxd_sync[0], rx_line};
  end
  assign link_rst = lrst_sync[1];

  // ------------------------------------------------------------
  // Link: transmitter
  // ------------------------------------------------------------
  tx_state_t  st, next_st;
  logic [7:0] hold_word, tx_shift;
  logic [2:0] tx_bit;
  logic       hold_full, take_word, word_end;

  assign take_word = (req_sync[1] != ack_tog) && !hold_full;
  assign word_end  = (tx_bit == `BIT_LAST);

  always_comb begin
    next_st = st;
    case (st)
      TX_IDLE: if (hold_full) next_st = TX_SEND;
      TX_SEND: if (word_end && !hold_full && end_sync[1] &&
                   !(req_sync[1] != ack_tog)) begin
        next_st = cc_sync[1] ? TX_IDLE : TX_PAD;
      end
      TX_PAD:  if (word_end) next_st = TX_IDLE;
      default: next_st = TX_IDLE;
    endcase
  end

  always_ff @(posedge dibit_transmit_clock) begin
    if (link_rst) begin
      hold_word <= '0;
      hold_full <= 1'b0;
      ack_tog   <= 1'b0;
    end else begin
      if (take_word) begin
        hold_word <= tx_word;
        hold_full <= 1'b1;
        ack_tog   <= ~ack_tog;
      end else if (hold_full && (st == TX_IDLE ||
                   (st == TX_SEND && word_end))) begin
        hold_full <= 1'b0;
      end
    end
  end

  always_ff @(posedge dibit_transmit_clock) begin
    if (link_rst) begin
      st                   <= TX_IDLE;
      tx_shift             <= '0;
      tx_bit               <= `BIT_FIRST;
      tx_line              <= 1'b0;
      request_to_send_lead <= 1'b0;
      done_tog             <= 1'b0;
    end else begin
      st <= next_st;
      // Rises on a link edge one step behind the state, so it also
      // spans the last bit still standing on the line
      request_to_send_lead <= (st != TX_IDLE);
      // Positive level sends zero, idle line marks ones
      tx_line <= (st == TX_IDLE) ? 1'b0 : ~tx_shift[0];
      tx_bit  <= (st == TX_IDLE) ? `BIT_FIRST : tx_bit + 1'b1;
      if (request_to_send_lead && st == TX_IDLE) begin
        done_tog <= ~done_tog;
      end
      if (st == TX_IDLE || word_end) begin
        if (next_st == TX_PAD) begin
          tx_shift <= `CHAR_PAD;
        end else if (hold_full) begin
          tx_shift <= hold_word;
        end else begin
          tx_shift <= `CHAR_SYN;
        end
      end else begin
        tx_shift <= {1'b0, tx_shift[7:1]};
      end
    end
  end

  // ------------------------------------------------------------
  // Link: receiver and shift-to-buffer timing chain
  // ------------------------------------------------------------
  logic [7:0] serial_shift_register;
  logic [2:0] rx_bit;
  logic       rx_shift_timing, rx_shift_interval, rx_shifter_clear;

  // Clear merges with the next first bit, so no bit is lost
  assign rx_shifter_clear = rx_shift_timing;

  always_ff @(posedge dibit_transmit_clock) begin
    if (link_rst || !rd_sync[1]) begin
      serial_shift_register <= '0;
      rx_bit                <= `BIT_FIRST;
      rx_shift_timing       <= 1'b0;
      rx_shift_interval     <= 1'b0;
    end else begin
      rx_shift_timing   <= (rx_bit == `BIT_LAST);
      rx_shift_interval <= rx_shift_timing;
      rx_bit            <= rx_bit + 1'b1;
      if (rx_shifter_clear) begin
        serial_shift_register <= {~rxd_sync[1], 7'h00};
      end else begin
        serial_shift_register <= {~rxd_sync[1],
                                  serial_shift_register[7:1]};
      end
    end
  end

  always_ff @(posedge dibit_transmit_clock) begin
    if (link_rst) begin
      receive_buffer <= '0;
      rx_tog         <= 1'b0;
    end else begin
      if (rx_shift_timing) begin
        receive_buffer <= serial_shift_register;
      end
      if (rx_shift_interval) begin
        rx_tog <= ~rx_tog;
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_qual;
    @(posedge core_clk) disable iff (rst)
    ##1 status.busy_online_qual ==
      $past(ctrl.processor_io_active && ctrl.online);
  endproperty
  a_qual: assert property (p_qual) else $error("qualifier wrong");

  property p_hang;
    @(posedge core_clk) disable iff (rst)
    ctrl.hangup_req |=> !line_control_lead [*8];
  endproperty
  a_hang: assert property (p_hang) else $error("lead not released");

  property p_ring;
    @(posedge core_clk) disable iff (rst)
    ring_sync[1] |=> status.service_request;
  endproperty
  a_ring: assert property (p_ring) else $error("ring missed");

  property p_read;
    @(posedge core_clk) disable iff (rst)
    (ctrl.start_read || (status.read_flag && !ctrl.stop_read)) |=>
      status.read_flag;
  endproperty
  a_read: assert property (p_read) else $error("read flag lost");

  property p_busy;
    @(posedge core_clk) disable iff (rst)
    (ctrl.start_write || ctrl.start_read) |=> status.channel_active_flag;
  endproperty
  a_busy: assert property (p_busy) else $error("busy not set");

  property p_dle;
    @(posedge core_clk) disable iff (rst)
    (dle_hold_flag && !fifo_valid) |=> $stable(req_tog);
  endproperty
  a_dle: assert property (p_dle) else $error("DLE left alone");

  property p_pad;
    @(posedge dibit_transmit_clock) disable iff (link_rst)
    (st == TX_SEND && next_st == TX_PAD) |=> tx_shift == `CHAR_PAD;
  endproperty
  a_pad: assert property (p_pad) else $error("pad not loaded");

  property p_nopad;
    @(posedge dibit_transmit_clock) disable iff (link_rst)
    (cc_sync[1] && st != TX_PAD) |=> st != TX_PAD;
  endproperty
  a_nopad: assert property (p_nopad) else $error("pad sent");

  property p_rts;
    @(posedge dibit_transmit_clock) disable iff (link_rst)
    !request_to_send_lead |-> !tx_line;
  endproperty
  a_rts: assert property (p_rts) else $error("rts mismatch");

  property p_late;
    @(posedge dibit_transmit_clock) disable iff (link_rst)
    (st == TX_SEND && word_end && hold_full) |=>
      tx_shift == $past(hold_word);
  endproperty
  a_late: assert property (p_late) else $error("late char lost");

  property p_rxbuf;
    @(posedge dibit_transmit_clock) disable iff (link_rst)
    rx_shift_timing |=> receive_buffer == $past(serial_shift_register) &&
      serial_shift_register[6:0] == 7'h00;
  endproperty
  a_rxbuf: assert property (p_rxbuf) else $error("rx chain wrong");
endmodule

// ### sca_far_model.sv
/*
  Far side model: synchronous modem and automatic calling unit.
  Assumes the adapter presents each send bit on a rising link edge.
*/
module sca_far_model (
  // Modem
  output logic       dibit_transmit_clock,
  output logic       rx_line,
  output logic       ring_indicator,
  input  wire logic  tx_line,
  input  wire logic  request_to_send_lead,
  // Calling unit
  output logic       next_digit_request,
  output logic       dialer_power_present,
  input  wire logic  digit_present,
  // Bench side
  input  wire logic  rx_ones,
  input  wire logic  ring,
  output logic [7:0] tx_byte,
  output logic       tx_stb
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] bit_cnt = 3'h0;
  logic [7:0] shift   = 8'h00;

  // Modem timing runs free, phase unrelated to the core clock
  initial begin
    dibit_transmit_clock = 1'b0;
    #3;
    forever #16 dibit_transmit_clock = ~dibit_transmit_clock;
  end

  // Negative level carries a one
  assign rx_line              = !rx_ones;
  assign ring_indicator       = ring;
  assign dialer_power_present = 1'b1;
  initial next_digit_request  = 1'b0;
  initial tx_stb              = 1'b0;
  initial tx_byte             = 8'h00;

  // Ask for a digit only once the last one is withdrawn
  always @(posedge dibit_transmit_clock)
    next_digit_request <= !digit_present;

  // Frame counting restarts whenever the request lead drops
  always @(negedge dibit_transmit_clock) begin
    tx_stb <= 1'b0;
    if (!request_to_send_lead) begin
      bit_cnt <= 3'h0;
    end else begin
      shift   <= {!tx_line, shift[7:1]};
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        tx_byte <= {!tx_line, shift[7:1]};
        tx_stb  <= 1'b1;
      end
    end
  end
endmodule

// ### tb_sca_modem.sv
/*
  Self-checking testbench of the modem and dialer signalling block.
  Assumes header, package, design and far side model compile first.
*/
`include "sca_modem_map.svh"
module tb_sca_modem
  import sca_modem_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic         core_clk   = 1'b0;
  logic         rst        = 1'b1;
  host_ctrl_t   ctrl       = '0;
  logic         tx_valid   = 1'b0;
  logic [7:0]   tx_char    = 8'h00;
  logic         dial_valid = 1'b0;
  logic [3:0]   dial_digit = 4'h0;
  logic         rx_ones    = 1'b1;
  logic         ring       = 1'b0;
  logic         last_dle   = 1'b0;
  logic [31:0]  rnd        = 32'h4754;
  logic [7:0]   c;
  logic [7:0]   tx_q[$];
  logic [7:0]   rx_q[$];
  int           err_total    = 0;
  int           total_checks = 0;
  int           cycles       = 0;
  int           n;
  host_status_t status;
  logic [7:0]   rx_char, tx_byte;
  logic [3:0]   digit_lead;
  logic         tx_ready, rx_char_valid, dial_ready, link_clk, rx_line;
  logic         tx_line, rts, lcl, ring_ind, ndr, pwr, dig_p, tx_stb;

  always #5 core_clk = ~core_clk;

  sca_modem #(.FIFO_DEPTH(8), .HANGUP_CYCLES(50)) i_dut (
    .core_clk(core_clk), .rst(rst), .ctrl(ctrl), .status(status),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_char(tx_char),
    .rx_char(rx_char), .rx_char_valid(rx_char_valid),
    .dial_valid(dial_valid), .dial_ready(dial_ready),
    .dial_digit(dial_digit), .dibit_transmit_clock(link_clk),
    .rx_line(rx_line), .tx_line(tx_line), .request_to_send_lead(rts),
    .line_control_lead(lcl), .ring_indicator(ring_ind),
    .next_digit_request(ndr), .dialer_power_present(pwr),
    .digit_lead(digit_lead), .digit_present(dig_p));

  sca_far_model i_far (
    .dibit_transmit_clock(link_clk), .rx_line(rx_line),
    .ring_indicator(ring_ind), .tx_line(tx_line),
    .request_to_send_lead(rts), .next_digit_request(ndr),
    .dialer_power_present(pwr), .digit_present(dig_p),
    .rx_ones(rx_ones), .ring(ring), .tx_byte(tx_byte), .tx_stb(tx_stb));

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  task check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // Random character that is neither a filler nor an escape
  task rchar();
    rnd = xs(rnd);
    c = rnd[7:0];
    if (c == `CHAR_SYN || c == `CHAR_DLE) c = 8'h41;
  endtask

  task pulse(input host_ctrl_t m);
    @(posedge core_clk) ctrl <= host_ctrl_t'(ctrl | m);
    @(posedge core_clk) ctrl <= host_ctrl_t'(ctrl & ~m);
  endtask

  task push(input logic [7:0] ch);
    tx_q.push_back(ch);
    @(posedge core_clk);
    tx_valid <= 1'b1;
    tx_char  <= ch;
    @(negedge core_clk);
    for (n = 0; n < 5000 && tx_ready !== 1'b1; n++) @(negedge core_clk);
    @(posedge core_clk);
    tx_valid <= 1'b0;
  endtask

  task wait_idle();
    for (n = 0; n < 3000 && status.channel_active_flag !== 1'b0; n++)
      @(negedge core_clk);
    check(8'(n < 3000), 8'h01);
  endtask

  task give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------
  // Result watchers
  // ----------------------------------------------------------
  // Fillers are skipped, except straight after an escape
  always @(posedge tx_stb) begin
    if (last_dle || tx_byte !== `CHAR_SYN)
      check(tx_byte, tx_q.size() ? tx_q.pop_front() : ~tx_byte);
    last_dle = (tx_byte === `CHAR_DLE);
  end

  always @(negedge core_clk)
    if (rx_char_valid === 1'b1)
      check(rx_char, rx_q.size() ? rx_q.pop_front() : ~rx_char);

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    repeat (10) @(posedge core_clk);
    for (int i = 0; i < 16; i++) begin
      rnd = xs(rnd);
      @(posedge core_clk);
      ctrl.online              <= rnd[0];
      ctrl.processor_io_active <= rnd[1];
      @(posedge core_clk);
      @(negedge core_clk);
      check(8'(status.busy_online_qual), 8'(rnd[0] & rnd[1]));
    end
    @(posedge core_clk);
    ctrl.online <= 1'b1;
    $display("test qualifier done");
    for (int i = 0; i < 8; i++) begin
      rchar();
      push((i == 3) ? `CHAR_DLE : c);
    end
    @(negedge core_clk);
    check(8'(tx_ready), 8'h00);
    tx_q.push_back(`CHAR_PAD);
    pulse('{start_write: 1'b1, default: 1'b0});
    pulse('{tx_last: 1'b1, default: 1'b0});
    wait_idle();
    check(8'(rts), 8'h00);
    check(8'(tx_q.size()), 8'h00);
    $display("test write with pad done");
    @(posedge core_clk);
    ctrl.const_carrier <= 1'b1;
    pulse('{start_write: 1'b1, default: 1'b0});
    push(`CHAR_DLE);
    repeat (100) @(posedge core_clk);
    rchar();
    push(c);
    repeat (80) @(posedge core_clk);
    rchar();
    push(c);
    pulse('{tx_last: 1'b1, default: 1'b0});
    wait_idle();
    repeat (60) @(posedge core_clk);
    check(8'(tx_q.size()), 8'h00);
    ctrl.const_carrier <= 1'b0;
    $display("test late escape done");
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      rx_ones <= (i == 0);
      repeat (20) @(posedge core_clk);
      repeat (2) rx_q.push_back((i == 0) ? 8'hff : 8'h00);
      pulse('{start_read: 1'b1, default: 1'b0});
      @(negedge core_clk);
      check(8'(status.read_flag), 8'h01);
      check(8'(status.channel_active_flag), 8'h01);
      for (n = 0; n < 2000 && rx_q.size() > 0; n++) @(negedge core_clk);
      pulse('{stop_read: 1'b1, default: 1'b0});
      wait_idle();
      check(8'(status.read_flag), 8'h00);
    end
    $display("test receive done");
    @(posedge core_clk) ring <= 1'b1;
    for (n = 0; n < 50 && status.service_request !== 1'b1; n++)
      @(negedge core_clk);
    check(8'(status.service_request), 8'h01);
    @(posedge core_clk) ring <= 1'b0;
    repeat (10) @(posedge core_clk);
    pulse('{svc_clear: 1'b1, default: 1'b0});
    @(negedge core_clk);
    check(8'(status.service_request), 8'h00);
    $display("test ring done");
    @(posedge core_clk) ctrl.answer_call <= 1'b1;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    check(8'(lcl), 8'h01);
    pulse('{hangup_req: 1'b1, default: 1'b0});
    n = 0;
    for (int k = 0; k < 200; k++) begin
      @(negedge core_clk);
      if (lcl === 1'b0) n++;
    end
    check(8'(n >= 45 && n <= 55), 8'h01);
    @(posedge core_clk) ctrl.answer_call <= 1'b0;
    $display("test hangup done");
    rnd = xs(rnd);
    @(posedge core_clk);
    ctrl.dial_active <= 1'b1;
    dial_digit       <= rnd[3:0];
    dial_valid       <= 1'b1;
    @(negedge core_clk);
    for (n = 0; n < 500 && dial_ready !== 1'b1; n++) @(negedge core_clk);
    @(posedge core_clk) dial_valid <= 1'b0;
    for (n = 0; n < 50 && dig_p !== 1'b1; n++) @(negedge core_clk);
    check(8'(digit_lead), 8'(rnd[3:0]));
    check(8'(lcl), 8'h01);
    check(8'(status.dialer_fault), 8'h00);
    @(posedge core_clk) ctrl.dial_active <= 1'b0;
    $display("test dial done");
    give_verdict();
  end
endmodule
